// file: hw/tccap_map.svh
// register offsets, field positions and reset values for the timer channel block
// assumes an 8-bit register port with a 3-bit address
// How it works
// R1 - capture edge sets channel event flag
// R2 - counter match sets compare event flag
// R3 - flag clears by read-set then zero write
// R4 - writing one leaves flag; reset clears
// R5 - interrupt request only while enable set
// R6 - buffer select only in channel 0
// R7 - buffered mode disables channel 1 events, control writes, pin ownership and request
// R8 - select bit picks capture or compare
// R9 - preset level: select one low, zero high
// R10 - zero edge field leaves pin to port, except in buffered mode
// R11 - capture on rising, falling or both
// R12 - compare toggles, clears or sets pin
// R13 - buffered mode applies same pin actions
// R14 - overflow toggles compare pin when enabled
// R15 - overflow action beats same-cycle compare
// R16 - full duty forces high when TOV set and edge field 10, period latency
// R17 - value registers hold capture or compare
// R18 - high read blocks capture until low read
// R19 - high write blocks compare until low write
// R20 - software halts counter before mode change
// R21 - software keeps pin steady before capture
// R22 - counter wraps at modulo, signals overflow
// R23 - counter halt suppresses input captures
`ifndef TCCAP_MAP_SVH
`define TCCAP_MAP_SVH
`define TCCAP_CTRL0 3'h0
`define TCCAP_VALH0 3'h1
`define TCCAP_VALL0 3'h2
`define TCCAP_CTRL1 3'h3
`define TCCAP_VALH1 3'h4
`define TCCAP_VALL1 3'h5
`define TCCAP_B_FLAG 7
`define TCCAP_B_IE 6
`define TCCAP_B_MSB 5
`define TCCAP_B_MSA 4
`define TCCAP_B_ELSB 3
`define TCCAP_B_ELSA 2
`define TCCAP_B_TOV 1
`define TCCAP_B_MAX 0
`define TCCAP_CTRL_RST 8'h00
`endif

// file: hw/tccap_pkg.sv
// types for the timer channel block
// assumes the map header supplies the numbers
package tccap_pkg;
  typedef enum logic [1:0] {
    TCCAP_PRESET = 2'b00,
    TCCAP_CAPTURE = 2'b01,
    TCCAP_COMPARE = 2'b10,
    TCCAP_BUFFERED = 2'b11
  } tccap_mode_t;
endpackage

// file: hw/tccap_channels.sv
// two capture/compare channels with their registers
// assumes counter, wrap pulse and halt come from the rest of the timer
`timescale 1ns/1ps
`include "tccap_map.svh"
module tccap_channels (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // shared counter
  input wire logic [15:0] counterValue,
  input wire logic counterWrap,
  input wire logic counterHalt,
  // channel pins
  input wire logic [1:0] channelPinIn,
  output logic [1:0] channelPinOut,
  output logic [1:0] channelPinOwn,
  // interrupt requests
  output logic [1:0] channelIrq
);
  import tccap_pkg::*;

  logic [7:0] ctrl_ff [2];
  logic [15:0] value_ff [2];
  logic [15:0] buffer_ff [2];
  logic [1:0] armed_ff;
  logic [1:0] capLock_ff;
  logic [1:0] cmpLock_ff;
  logic [7:0] latchLow_ff [2];
  logic [1:0] pinPrev_ff;
  logic [1:0] level_ff;
  logic [1:0] maxAct_ff;
  logic [1:0] own_ff;
  logic [1:0] irq_ff;
  logic [7:0] rd_ff;
  logic [1:0] bufDirty_ff;
  tccap_mode_t mode [2];
  logic [1:0] capEvt;
  logic [1:0] cmpEvt;
  logic [1:0] live;
  logic [1:0] nxtLevel;

  // R8 select bit picks mode
  function automatic tccap_mode_t decode(input logic [7:0] c, input logic b);
    if (b) begin
      decode = TCCAP_BUFFERED;
    end else if (c[`TCCAP_B_ELSB:`TCCAP_B_ELSA] == 2'b00) begin
      decode = TCCAP_PRESET;
    end else if (c[`TCCAP_B_MSA]) begin
      decode = TCCAP_COMPARE;
    end else begin
      decode = TCCAP_CAPTURE;
    end
  endfunction

  // channel event detection
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic [1:0] els;
      logic rise;
      logic fall;
      logic [15:0] cmpVal;
      els = ctrl_ff[i][`TCCAP_B_ELSB:`TCCAP_B_ELSA];
      // R6 buffer select only in channel 0
      mode[i] = decode(ctrl_ff[i], (i == 0) ? ctrl_ff[0][`TCCAP_B_MSB] : 1'b0);
      // R7 channel 1 off in buffered mode
      live[i] = (i == 1) ? ~ctrl_ff[0][`TCCAP_B_MSB] : 1'b1;
      rise = ~pinPrev_ff[i] & channelPinIn[i];
      fall = pinPrev_ff[i] & ~channelPinIn[i];
      // R11 capture edge select, R23 halt blocks capture, R18 read lock
      capEvt[i] = live[i] && mode[i] == TCCAP_CAPTURE && !counterHalt && !capLock_ff[i]
        && ((els[0] & rise) | (els[1] & fall));
      // R13 buffered pair compares channel 0's active copy
      cmpVal = (mode[0] == TCCAP_BUFFERED && i == 0) ? buffer_ff[0] : value_ff[i];
      // R2 counter match, R19 write lock
      cmpEvt[i] = live[i] && (mode[i] == TCCAP_COMPARE || mode[i] == TCCAP_BUFFERED)
        && !cmpLock_ff[i] && counterValue == cmpVal;
    end
  end

  // pin level: full duty first, then overflow, then compare action
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic [1:0] els;
      logic tov;
      els = ctrl_ff[i][`TCCAP_B_ELSB:`TCCAP_B_ELSA];
      tov = ctrl_ff[i][`TCCAP_B_TOV];
      nxtLevel[i] = level_ff[i];
      if (mode[i] == TCCAP_PRESET) begin
        // R9 preset level from select bit
        nxtLevel[i] = ~ctrl_ff[i][`TCCAP_B_MSA];
      end else if (mode[i] == TCCAP_CAPTURE) begin
        nxtLevel[i] = level_ff[i];
      end else if (maxAct_ff[i] && tov && els == 2'b10) begin
        // R16 full duty holds output high
        nxtLevel[i] = 1'b1;
      end else if (tov && counterWrap) begin
        // R14 toggle on wrap, R15 wrap wins
        nxtLevel[i] = ~level_ff[i];
      end else if (cmpEvt[i]) begin
        // R12 compare pin action
        case (els)
          2'b01: nxtLevel[i] = ~level_ff[i];
          2'b10: nxtLevel[i] = 1'b0;
          2'b11: nxtLevel[i] = 1'b1;
          default: nxtLevel[i] = level_ff[i];
        endcase
      end
    end
  end

  // control registers and flags
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      logic [2:0] ca;
      logic hit;
      ca = (i == 0) ? `TCCAP_CTRL0 : `TCCAP_CTRL1;
      if (rst) begin
        // R4 reset clears flag and fields
        ctrl_ff[i] <= `TCCAP_CTRL_RST;
        armed_ff[i] <= 1'b0;
      end else begin
        // R1 R2 event sets flag
        hit = capEvt[i] | cmpEvt[i];
        if (regRd && regAddr == ca && ctrl_ff[i][`TCCAP_B_FLAG]) begin
          armed_ff[i] <= 1'b1;
        end
        if (regWr && regAddr == ca && (live[i] || i == 0)) begin
          ctrl_ff[i][6:0] <= regWrData[6:0];
          if (i == 1) begin
            ctrl_ff[i][`TCCAP_B_MSB] <= 1'b0;
          end
          // R3 zero write clears only after armed read
          if (hit) begin
            ctrl_ff[i][`TCCAP_B_FLAG] <= 1'b1;
          end else if (!regWrData[`TCCAP_B_FLAG] && armed_ff[i]) begin
            ctrl_ff[i][`TCCAP_B_FLAG] <= 1'b0;
          end
          armed_ff[i] <= 1'b0;
        end else if (hit) begin
          ctrl_ff[i][`TCCAP_B_FLAG] <= 1'b1;
          // R3 new event voids pending clear
          armed_ff[i] <= 1'b0;
        end
      end
    end
  end

  // value registers with byte locks
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      logic [2:0] ha;
      logic [2:0] la;
      ha = (i == 0) ? `TCCAP_VALH0 : `TCCAP_VALH1;
      la = (i == 0) ? `TCCAP_VALL0 : `TCCAP_VALL1;
      if (rst) begin
        capLock_ff[i] <= 1'b0;
        cmpLock_ff[i] <= 1'b0;
        bufDirty_ff[i] <= 1'b0;
      end else begin
        // R17 capture stores counter
        if (capEvt[i]) begin
          value_ff[i] <= counterValue;
        end
        if (regWr && regAddr == ha) begin
          value_ff[i][15:8] <= regWrData;
          // R19 lock until low write
          cmpLock_ff[i] <= mode[i] != TCCAP_CAPTURE;
        end
        if (regWr && regAddr == la) begin
          value_ff[i][7:0] <= regWrData;
          cmpLock_ff[i] <= 1'b0;
          bufDirty_ff[i] <= 1'b1;
        end
        if (regRd && regAddr == ha) begin
          // R18 lock until low read
          capLock_ff[i] <= mode[i] == TCCAP_CAPTURE;
        end
        if (regRd && regAddr == la) begin
          capLock_ff[i] <= 1'b0;
        end
        // R13 R22 buffered copy loads at wrap
        if (counterWrap && bufDirty_ff[i] && !(regWr && regAddr == la)) begin
          buffer_ff[i] <= value_ff[i];
          bufDirty_ff[i] <= 1'b0;
        end
      end
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ff <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `TCCAP_CTRL0: rd_ff <= ctrl_ff[0];
        `TCCAP_VALH0: rd_ff <= value_ff[0][15:8];
        `TCCAP_VALL0: rd_ff <= value_ff[0][7:0];
        `TCCAP_CTRL1: rd_ff <= ctrl_ff[1];
        `TCCAP_VALH1: rd_ff <= value_ff[1][15:8];
        `TCCAP_VALL1: rd_ff <= value_ff[1][7:0];
        default: rd_ff <= 8'h00;
      endcase
    end else begin
      rd_ff <= 8'h00;
    end
  end

  // pin state, full duty latch, interrupts
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        pinPrev_ff[i] <= 1'b0;
        level_ff[i] <= 1'b1;
        maxAct_ff[i] <= 1'b0;
        own_ff[i] <= 1'b0;
        irq_ff[i] <= 1'b0;
      end else begin
        pinPrev_ff[i] <= channelPinIn[i];
        level_ff[i] <= nxtLevel[i];
        // R16 full duty follows at period boundary
        if (counterWrap) begin
          maxAct_ff[i] <= ctrl_ff[i][`TCCAP_B_MAX];
        end
        // R10 R7 pin owned only when enabled
        own_ff[i] <= live[i] && mode[i] != TCCAP_PRESET && mode[i] != TCCAP_CAPTURE;
        // R5 request gated by enable
        irq_ff[i] <= ctrl_ff[i][`TCCAP_B_FLAG] & ctrl_ff[i][`TCCAP_B_IE] & live[i];
      end
    end
  end

  assign regRdData = rd_ff;
  assign channelPinOut = level_ff;
  assign channelPinOwn = own_ff;
  assign channelIrq = irq_ff;
endmodule

// file: test/tccap_channels_sva.sv
// port checker for the timer channel block
// assumes a bind onto tccap_channels, one clock
`timescale 1ns/1ps
`include "tccap_map.svh"
module tccap_channels_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // pins and requests
  input wire logic [1:0] channelPinOwn,
  input wire logic [1:0] channelIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic bufOn_ff;
  always_ff @(posedge clk) begin
    if (rst)
      bufOn_ff <= 1'b0;
    else if (regWr && regAddr == `TCCAP_CTRL0)
      bufOn_ff <= regWrData[`TCCAP_B_MSB];
  end
  sequence sRd0; regRd && regAddr == `TCCAP_CTRL0; endsequence
  sequence sRd1; regRd && regAddr == `TCCAP_CTRL1; endsequence
  sequence sPre0; regWr && regAddr == `TCCAP_CTRL0 && regWrData[3:2] == 2'b00; endsequence
  a_rd_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not zero");
  a_rd_nobuf1: assert property (sRd1 |=> !regRdData[`TCCAP_B_MSB])
    else $error("buffer bit in channel 1");
  a_rd_buf0: assert property (sRd0 |=> regRdData[`TCCAP_B_MSB] == $past(bufOn_ff))
    else $error("buffer bit lost");
  a_reset_quiet: assert property ($fell(rst) |-> channelIrq == 2'b00 && channelPinOwn == 2'b00)
    else $error("outputs not cleared by reset");
  a_own_cause: assert property ($changed(channelPinOwn) |-> $past(regWr) || $past(regWr, 2))
    else $error("pin ownership moved alone");
  a_preset_free: assert property (sPre0 |-> ##[1:3] !channelPinOwn[0])
    else $error("preset kept pin");
  a_irq_fall: assert property ($fell(channelIrq[0]) || $fell(channelIrq[1]) |->
    $past(regWr) || $past(regWr, 2) || $past(regWr, 3))
    else $error("request dropped without write");
  a_buf_frees: assert property (bufOn_ff [*3] |-> !channelPinOwn[1])
    else $error("channel 1 kept pin");
endmodule

// file: test/test_timer_channel_capture_compare.sv
// self-checking bench for the timer channel block
// assumes design and checker files compiled first
`timescale 1ns/1ps
`include "tccap_map.svh"
module test_timer_channel_capture_compare;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic [15:0] counterValue = 16'h0000;
  logic counterWrap = 1'b0;
  logic counterHalt = 1'b0;
  logic [1:0] channelPinIn = 2'b00;
  logic [1:0] channelPinOut, channelPinOwn, channelIrq;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  int expPin = 0;
  logic [15:0] cnt;
  always #2 clk = ~clk;
  tccap_channels dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .counterValue(counterValue),
    .counterWrap(counterWrap), .counterHalt(counterHalt), .channelPinIn(channelPinIn),
    .channelPinOut(channelPinOut), .channelPinOwn(channelPinOwn), .channelIrq(channelIrq));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [5:0] e, input logic [5:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    cmp_count++;
    if ((regRdData & m) !== e) begin
      err_total++;
      $display("mismatch reg %0d expected %h seen %h", a, e, regRdData & m);
    end
  endtask
  // drive one pin edge, check flag, value and request, then clear
  task automatic edge0(input logic lvl, input logic expF, input logic [7:0] ctl);
    @(posedge clk);
    channelPinIn[0] <= lvl;
    repeat (3) @(posedge clk);
    rdc(`TCCAP_CTRL0, 8'h80, {expF, 7'h00});
    if (expF) begin
      rdc(`TCCAP_VALH0, 8'hff, cnt[15:8]);
      rdc(`TCCAP_VALL0, 8'hff, cnt[7:0]);
    end
    chk("irq", {5'h0, expF}, {5'h0, channelIrq[0]});
    wr(`TCCAP_CTRL0, ctl | 8'h80);
    rdc(`TCCAP_CTRL0, 8'h80, {expF, 7'h00});
    wr(`TCCAP_CTRL0, ctl);
    rdc(`TCCAP_CTRL0, 8'h80, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    void'($urandom(48));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(`TCCAP_CTRL0, 8'hff, `TCCAP_CTRL_RST);
    rdc(`TCCAP_CTRL1, 8'hff, `TCCAP_CTRL_RST);
    chk("own out irq", 6'h0c, {channelPinOwn, channelPinOut, channelIrq});
    $display("reset test done");
    for (int c = 1; c < 4; c++) begin
      cnt = 16'($urandom);
      counterValue <= cnt;
      wr(`TCCAP_CTRL0, 8'h40 | (8'(c) << 2));
      edge0(1'b1, c[0], 8'h40 | (8'(c) << 2));
      edge0(1'b0, c[1], 8'h40 | (8'(c) << 2));
    end
    counterHalt <= 1'b1;
    edge0(1'b1, 1'b0, 8'h4c);
    edge0(1'b0, 1'b0, 8'h4c);
    counterHalt <= 1'b0;
    $display("capture test done");
    wr(`TCCAP_CTRL0, 8'h10);
    repeat (2) @(posedge clk);
    chk("preset", 6'h00, {4'h0, channelPinOwn[0], channelPinOut[0]});
    for (int c = 3; c > 0; c--) begin
      cnt = 16'($urandom);
      wr(`TCCAP_CTRL0, 8'h10 | (8'(c) << 2));
      wr(`TCCAP_VALH0, cnt[15:8]);
      wr(`TCCAP_VALL0, cnt[7:0]);
      @(posedge clk) counterValue <= cnt;
      @(posedge clk) counterValue <= cnt + 16'h0001;
      repeat (3) @(posedge clk);
      expPin = (c == 3) ? 1 : (c == 2) ? 0 : 1 - expPin;
      chk("cmp pin", 6'h02 | 6'(expPin), {4'h0, channelPinOwn[0], channelPinOut[0]});
      rdc(`TCCAP_CTRL0, 8'h80, 8'h80);
    end
    wr(`TCCAP_CTRL0, 8'h16);
    @(posedge clk) counterWrap <= 1'b1;
    @(posedge clk) counterWrap <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wrap pin", 6'h02 | 6'(1 - expPin), {4'h0, channelPinOwn[0], channelPinOut[0]});
    $display("compare test done");
    wr(`TCCAP_CTRL1, 8'h34);
    repeat (3) @(posedge clk);
    chk("own1", 6'h01, {5'h0, channelPinOwn[1]});
    wr(`TCCAP_CTRL0, 8'h28);
    rdc(`TCCAP_CTRL1, 8'h20, 8'h00);
    rdc(`TCCAP_CTRL0, 8'h20, 8'h20);
    chk("own1 buf", 6'h00, {5'h0, channelPinOwn[1]});
    $display("buffer test done");
    test_done();
  end
endmodule
bind tccap_channels tccap_channels_sva chk_i (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .channelPinOwn(channelPinOwn), .channelIrq(channelIrq));
